// ==== verilog/dcocr_bank.sv ====
`timescale 1ns/10ps
// How it works
// - Drive field decodes four load types
// - Level field decodes gain steps, resets 0 dB
// - Impedance bit picks 4.4k or 20k
// - Full-scale bit picks 2 or 4 Vrms
// - Coupling bit picks tolerance range
// - Volume code: mute, -100 dB upward, resets 201
// - Fine gain code: -0.8 dB upward, resets 8
// - Fine gain low nibble reads zero
// - Bandwidth select 0 is audio band
module dcocr_bank
	import dcocr_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire logic [7:0]          reg_addr,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [7:0]          reg_wdata,
	output logic      [7:0]          reg_rdata,
	input  wire logic                ch2_bandwidth_sel,
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] sample_in,
	output logic      [SAMPLE_W-1:0] sample_out,
	output logic                     sample_out_valid,
	output dcocr_drive_t             neg_leg_drive_sel,
	output logic      [2:0]          neg_leg_level_sel,
	output logic                     neg_leg_level_reserved,
	output logic                     pos_bypass_impedance,
	output logic                     ch2_fullscale_sel,
	output logic                     ch2_fullscale_unsupported,
	output logic                     ch2_common_mode_tolerance,
	output logic      [7:0]          ch2a_volume_code,
	output logic                     ch2a_mute,
	output logic      [3:0]          ch2a_fine_gain_code
);
	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0] output2_config_two;
	logic [7:0] dac2a_volume;
	logic [7:0] dac2a_fine_gain;
	logic [7:0] next_output2_config_two;
	logic [7:0] next_dac2a_volume;
	logic [7:0] next_dac2a_fine_gain;
	logic [7:0] next_reg_rdata;

	// Write decode; read-only nibble is dropped so it can never set
	always_comb begin
		next_output2_config_two = output2_config_two;
		next_dac2a_volume = dac2a_volume;
		next_dac2a_fine_gain = dac2a_fine_gain;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_OUTPUT2_CONFIG_TWO: begin
					next_output2_config_two = reg_wdata;
				end
				ADDR_DAC2A_VOLUME: begin
					next_dac2a_volume = reg_wdata;
				end
				ADDR_DAC2A_FINE_GAIN: begin
					next_dac2a_fine_gain = reg_wdata & ~FGAIN_RO_MASK;
				end
				default: begin
					next_output2_config_two = output2_config_two;
				end
			endcase
		end
	end

	// Read mux; unmapped addresses answer zero
	always_comb begin
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_OUTPUT2_CONFIG_TWO: next_reg_rdata = output2_config_two;
				ADDR_DAC2A_VOLUME:       next_reg_rdata = dac2a_volume;
				ADDR_DAC2A_FINE_GAIN:    next_reg_rdata = dac2a_fine_gain & ~FGAIN_RO_MASK;
				default:                 next_reg_rdata = 8'h00;
			endcase
		end
	end

	// Register update and read data flop
	always_ff @(posedge mclk) begin
		if (rst) begin
			output2_config_two <= RST_OUTPUT2_CONFIG_TWO;
			dac2a_volume <= RST_DAC2A_VOLUME;
			dac2a_fine_gain <= RST_DAC2A_FINE_GAIN;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			output2_config_two <= next_output2_config_two;
			dac2a_volume <= next_dac2a_volume;
			dac2a_fine_gain <= next_dac2a_fine_gain;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Field decode to the analog drivers
	// ----------------------------------------------------------------
	// Reserved level code is flagged rather than remapped, so the
	// analog side can hold its last safe setting
	always_comb begin
		case (output2_config_two[DRIVE_LSB +: 2])
			2'h0:    neg_leg_drive_sel = DCOCR_LINE_OUT;
			2'h1:    neg_leg_drive_sel = DCOCR_HEADPHONE;
			2'h2:    neg_leg_drive_sel = DCOCR_FOUR_OHM;
			default: neg_leg_drive_sel = DCOCR_RECEIVER;
		endcase
		neg_leg_level_sel = output2_config_two[LEVEL_LSB +: 3];
		neg_leg_level_reserved = neg_leg_level_sel == LEVEL_RESERVED;
		pos_bypass_impedance = output2_config_two[IMP_BIT];
		ch2_fullscale_sel = output2_config_two[FS_BIT];
		// High full-scale only valid in audio band (select 0)
		ch2_fullscale_unsupported = ch2_fullscale_sel & ch2_bandwidth_sel;
		ch2_common_mode_tolerance = output2_config_two[CMTOL_BIT];
		ch2a_volume_code = dac2a_volume;
		ch2a_mute = dac2a_volume == VOL_MUTE;
		ch2a_fine_gain_code = dac2a_fine_gain[FGAIN_LSB +: 4];
	end

	// ----------------------------------------------------------------
	// Gain stage
	// ----------------------------------------------------------------
	dcocr_cfg_if cfg_link ();
	assign cfg_link.volume_code = dac2a_volume;
	assign cfg_link.fine_code = dac2a_fine_gain[FGAIN_LSB +: 4];

	dcocr_gain #(
		.SAMPLE_W(SAMPLE_W)
	) u_gain (
		.mclk             (mclk),
		.rst              (rst),
		.ce               (ce),
		.cfg              (cfg_link.gain),
		.sample_valid     (sample_valid),
		.sample_in        (sample_in),
		.sample_out       (sample_out),
		.sample_out_valid (sample_out_valid)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Read-only nibble must stay clear whatever software writes there
	a_ro_nibble_zero: assert property (@(posedge mclk) disable iff (rst)
		(dac2a_fine_gain & FGAIN_RO_MASK) == 8'h00)
		else $error("fine gain low nibble not zero");
	// Reads of the fine gain register never show the read-only nibble
	a_read_fine: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_rd && reg_addr == ADDR_DAC2A_FINE_GAIN |=> reg_rdata[3:0] == 4'h0)
		else $error("read-only nibble read nonzero");
	// Volume and fine gain writes reach the gain stage one edge later
	a_vol_write_lands: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_DAC2A_VOLUME
		|=> ch2a_volume_code == $past(reg_wdata))
		else $error("volume write lost");
	a_fine_write_lands: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_DAC2A_FINE_GAIN
		|=> ch2a_fine_gain_code == $past(reg_wdata[7:4]))
		else $error("fine gain write lost");
	// A written zero volume code must raise the mute flag
	a_mute_flag: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_DAC2A_VOLUME && reg_wdata == VOL_MUTE
		|=> ch2a_mute)
		else $error("mute flag not raised");
	// Reset state: line-out drive at 0 dB, unity volume and fine gain
	a_level_reset_zero: assert property (@(posedge mclk)
		rst |=> neg_leg_level_sel == LEVEL_ZERO_DB
			&& neg_leg_drive_sel == DCOCR_LINE_OUT)
		else $error("level not 0 dB after reset");
	a_reset_gains: assert property (@(posedge mclk)
		rst |=> ch2a_volume_code == VOL_UNITY && ch2a_fine_gain_code == FGAIN_UNITY)
		else $error("gain reset wrong");
	// Drive field decodes to one load type per code
	a_drive_decode: assert property (@(posedge mclk) disable iff (rst)
		output2_config_two[DRIVE_LSB +: 2] == 2'h1 |-> neg_leg_drive_sel == DCOCR_HEADPHONE)
		else $error("drive decode wrong");
	a_drive_receiver: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_OUTPUT2_CONFIG_TWO && reg_wdata[7:6] == 2'h3
		|=> neg_leg_drive_sel == DCOCR_RECEIVER)
		else $error("receiver drive not selected");
	// Level write lands, and the reserved code is flagged, not dropped
	a_level_write_lands: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_OUTPUT2_CONFIG_TWO
		|=> neg_leg_level_sel == $past(reg_wdata[5:3]))
		else $error("level write lost");
	a_level_reserved: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_OUTPUT2_CONFIG_TWO
			&& reg_wdata[5:3] == LEVEL_RESERVED
		|=> neg_leg_level_reserved)
		else $error("reserved level not flagged");
	// Single-bit options of the output config register
	a_impedance_bit: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_OUTPUT2_CONFIG_TWO
		|=> pos_bypass_impedance == $past(reg_wdata[2])
			&& ch2_fullscale_sel == $past(reg_wdata[1]))
		else $error("impedance or full-scale bit wrong");
	a_cm_tol_bit: assert property (@(posedge mclk) disable iff (rst)
		ce && reg_wr && reg_addr == ADDR_OUTPUT2_CONFIG_TWO
		|=> ch2_common_mode_tolerance == $past(reg_wdata[0]))
		else $error("tolerance bit wrong");
	// Flag follows the stored full-scale bit and the live band select
	a_fs_bw_flag: assert property (@(posedge mclk) disable iff (rst)
		ch2_fullscale_unsupported == (output2_config_two[FS_BIT] && ch2_bandwidth_sel))
		else $error("full-scale flag wrong");
	// Clock enable low freezes the bank; read data stands until the next read
	a_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
		!ce |=> $stable(output2_config_two) && $stable(dac2a_volume)
			&& $stable(dac2a_fine_gain))
		else $error("bank changed with clock enable low");
	a_rdata_holds: assert property (@(posedge mclk) disable iff (rst)
		!(ce && reg_rd) |=> $stable(reg_rdata))
		else $error("read data changed without a read");
endmodule

// ==== verilog/dcocr_pkg.sv ====
package dcocr_pkg;
	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OUTPUT2_CONFIG_TWO = 8'h6D;
	localparam logic [7:0] ADDR_DAC2A_VOLUME       = 8'h6E;
	localparam logic [7:0] ADDR_DAC2A_FINE_GAIN    = 8'h6F;
	localparam logic [7:0] RST_OUTPUT2_CONFIG_TWO  = 8'h20;
	localparam logic [7:0] RST_DAC2A_VOLUME        = 8'hC9;
	localparam logic [7:0] RST_DAC2A_FINE_GAIN     = 8'h80;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DRIVE_LSB    = 6;
	localparam int LEVEL_LSB    = 3;
	localparam int IMP_BIT      = 2;
	localparam int FS_BIT       = 1;
	localparam int CMTOL_BIT    = 0;
	localparam int FGAIN_LSB    = 4;
	localparam logic [7:0] FGAIN_RO_MASK = 8'h0F;
	// ----------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------
	localparam logic [2:0] LEVEL_RESERVED = 3'h7;
	localparam logic [2:0] LEVEL_ZERO_DB  = 3'h4;
	localparam logic [7:0] VOL_MUTE       = 8'h00;
	localparam logic [7:0] VOL_UNITY      = 8'hC9;
	localparam logic [3:0] FGAIN_UNITY    = 4'h8;
	typedef enum logic [3:0] {
		DCOCR_LINE_OUT  = 4'b0001,
		DCOCR_HEADPHONE = 4'b0010,
		DCOCR_FOUR_OHM  = 4'b0100,
		DCOCR_RECEIVER  = 4'b1000
	} dcocr_drive_t;
endpackage

// ==== verilog/dcocr_cfg_if.sv ====
`timescale 1ns/10ps
// Decoded settings passed from register bank to the gain stage
interface dcocr_cfg_if;
	logic [7:0] volume_code;
	logic [3:0] fine_code;
	modport bank (output volume_code, output fine_code);
	modport gain (input volume_code, input fine_code);
endinterface

// ==== verilog/dcocr_gain.sv ====
`timescale 1ns/10ps
// Digital gain stage for channel 2A samples
module dcocr_gain
	import dcocr_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic                ce,
	dcocr_cfg_if.gain                cfg,
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] sample_in,
	output logic      [SAMPLE_W-1:0] sample_out,
	output logic                     sample_out_valid
);
	// ----------------------------------------------------------------
	// Gain arithmetic
	// ----------------------------------------------------------------
	// Linear approximation: 0.5 dB steps become Q12 factors by two linear
	// segments split at unity; exact curve belongs to a later DSP revision
	function automatic logic [15:0] vol_factor(input logic [7:0] code);
		logic [15:0] f;
		f = 16'h0000;
		if (code == VOL_MUTE) begin
			f = 16'h0000;
		end else if (code >= VOL_UNITY) begin
			f = 16'h1000 + {code - VOL_UNITY, 6'h00};
		end else begin
			f = {4'h0, code, 4'h0} >> 3'h3;
		end
		return f;
	endfunction

	logic signed [SAMPLE_W+32:0] prod;
	logic [15:0]                 fine_f;
	logic [SAMPLE_W-1:0]         next_sample_out;
	logic                        next_valid;

	// Combine volume and fine gain, force zero on mute
	always_comb begin
		// Anchored so code 8 is exact unity; about 0.1 dB per step either side
		fine_f = 16'h0E88 + 16'(cfg.fine_code) * 16'h002F;
		prod = $signed({{33{sample_in[SAMPLE_W-1]}}, sample_in})
			* $signed({17'h00000, vol_factor(cfg.volume_code)})
			* $signed({17'h00000, fine_f});
		next_sample_out = sample_out;
		next_valid = 1'b0;
		if (sample_valid) begin
			next_valid = 1'b1;
			if (cfg.volume_code == VOL_MUTE) begin
				next_sample_out = '0;
			end else begin
				next_sample_out = prod[SAMPLE_W+23:24];
			end
		end
	end

	// Output register
	always_ff @(posedge mclk) begin
		if (rst) begin
			sample_out <= '0;
			sample_out_valid <= 1'b0;
		end else if (ce) begin
			sample_out <= next_sample_out;
			sample_out_valid <= next_valid;
		end
	end

	a_mute_forces_zero: assert property (@(posedge mclk) disable iff (rst)
		ce && sample_valid && cfg.volume_code == VOL_MUTE |=> sample_out == '0)
		else $error("muted sample not zero");
	a_valid_follows: assert property (@(posedge mclk) disable iff (rst)
		ce && sample_valid |=> sample_out_valid)
		else $error("output valid did not follow input");
endmodule

// ==== tb/dcocr_bank_test.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Compare helper: counts every check, reports a mismatch at once
// ----------------------------------------------------------------
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, (e), (g)); end end
module dcocr_bank_test;
	import dcocr_pkg::*;
	logic                mclk, rst, ce, reg_wr, reg_rd, ch2_bandwidth_sel, sample_valid;
	logic         [7:0]  reg_addr, reg_wdata, reg_rdata, ch2a_volume_code, d;
	logic         [23:0] sample_in, sample_out;
	logic         [2:0]  neg_leg_level_sel;
	logic         [3:0]  ch2a_fine_gain_code;
	logic                sample_out_valid, neg_leg_level_reserved, pos_bypass_impedance;
	logic                ch2_fullscale_sel, ch2_fullscale_unsupported, ch2_mid, ch2a_mute;
	dcocr_drive_t        neg_leg_drive_sel;
	int                  fail_count, comparisons;
	logic         [7:0]  vols [4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};

	dcocr_bank #(.SAMPLE_W(24)) dut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ch2_bandwidth_sel(ch2_bandwidth_sel), .sample_valid(sample_valid),
		.sample_in(sample_in), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
		.neg_leg_drive_sel(neg_leg_drive_sel), .neg_leg_level_sel(neg_leg_level_sel),
		.neg_leg_level_reserved(neg_leg_level_reserved),
		.pos_bypass_impedance(pos_bypass_impedance), .ch2_fullscale_sel(ch2_fullscale_sel),
		.ch2_fullscale_unsupported(ch2_fullscale_unsupported),
		.ch2_common_mode_tolerance(ch2_mid), .ch2a_volume_code(ch2a_volume_code),
		.ch2a_mute(ch2a_mute), .ch2a_fine_gain_code(ch2a_fine_gain_code));

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// Access tasks: a spare cycle after each strobe so it never re-rises in one step
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		@(posedge mclk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		v = reg_rdata;
		@(posedge mclk);
		#1;
	endtask

	// Sample out follows its input by exactly one edge; value checked where rules fix it
	task automatic send_sample(input logic do_check, input logic [23:0] expected);
		sample_in = 24'h123456;
		sample_valid = 1'b1;
		@(posedge mclk);
		#1;
		sample_valid = 1'b0;
		`CHK("sample valid", 1'b1, sample_out_valid)
		if (do_check) `CHK("sample out", expected, sample_out)
		@(posedge mclk);
		#1;
		`CHK("valid pulse", 1'b0, sample_out_valid)
	endtask

	task automatic end_of_test;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, ce, reg_wr, reg_rd, ch2_bandwidth_sel, sample_valid} = 6'b110000;
		{reg_addr, reg_wdata, sample_in} = 40'h0;
		repeat (8) @(posedge mclk);
		#1;
		rst = 1'b0;
		rd(ADDR_OUTPUT2_CONFIG_TWO, d); `CHK("cfg two reset", 8'h20, d)
		rd(ADDR_DAC2A_VOLUME, d); `CHK("volume reset", 8'hC9, d)
		rd(ADDR_DAC2A_FINE_GAIN, d); `CHK("fine reset", 8'h80, d)
		`CHK("drive reset", 4'b0001, neg_leg_drive_sel)
		`CHK("level reset", 3'h4, neg_leg_level_sel)
		`CHK("bits reset", 3'b000, {pos_bypass_impedance, ch2_fullscale_sel, ch2_mid})
		for (int i = 0; i < 4; i++) begin
			wr(8'h6D, 8'(i << 6));
			`CHK("drive", 4'(1 << i), neg_leg_drive_sel)
		end
		// Reserved level is kept and flagged, never blocked
		for (int i = 0; i < 8; i++) begin
			wr(8'h6D, 8'(i << 3)); // impedance bit stays clear, so code 6 is legal
			`CHK("level", 3'(i), neg_leg_level_sel)
			`CHK("level reserved", 1'(i == 7), neg_leg_level_reserved)
		end
		for (int i = 0; i < 3; i++) begin
			wr(8'h6D, 8'(1 << i));
			`CHK("single bits", 3'(1 << i), {pos_bypass_impedance, ch2_fullscale_sel, ch2_mid})
		end
		wr(8'h6D, 8'h02);
		ch2_bandwidth_sel = 1'b1;
		@(posedge mclk);
		#1;
		`CHK("fullscale wide band", 1'b1, ch2_fullscale_unsupported)
		ch2_bandwidth_sel = 1'b0;
		@(posedge mclk);
		#1;
		`CHK("fullscale audio band", 1'b0, ch2_fullscale_unsupported)
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_DAC2A_VOLUME, vols[i]);
			rd(ADDR_DAC2A_VOLUME, d); `CHK("volume read", vols[i], d)
			`CHK("volume code", vols[i], ch2a_volume_code)
			`CHK("mute", 1'(vols[i] == 8'h00), ch2a_mute)
			// Mute gives zero; 0 dB volume with 0 dB fine gain passes the sample unchanged
			send_sample(vols[i] == VOL_MUTE || vols[i] == VOL_UNITY,
				(vols[i] == VOL_MUTE) ? 24'h000000 : 24'h123456);
		end
		wr(ADDR_DAC2A_FINE_GAIN, 8'hFF);
		`CHK("fine code top", 4'hF, ch2a_fine_gain_code)
		rd(ADDR_DAC2A_FINE_GAIN, d); `CHK("fine low nibble", 8'hF0, d)
		wr(ADDR_DAC2A_FINE_GAIN, 8'h0F);
		`CHK("fine code bottom", 4'h0, ch2a_fine_gain_code)
		rd(ADDR_DAC2A_FINE_GAIN, d); `CHK("fine ro bits", 8'h00, d)
		// Unmapped neighbour: write dropped, read gives zero
		wr(8'h6C, 8'h55);
		rd(8'h6C, d); `CHK("unmapped read", 8'h00, d)
		rd(ADDR_OUTPUT2_CONFIG_TWO, d); `CHK("cfg two kept", 8'h02, d)
		// Clock enable low must freeze the bank
		ce = 1'b0;
		wr(ADDR_DAC2A_VOLUME, 8'h33);
		ce = 1'b1;
		`CHK("frozen volume", 8'hFF, ch2a_volume_code)
		// Reset in mid-run restores every register
		rst = 1'b1;
		@(posedge mclk);
		#1;
		rst = 1'b0;
		rd(ADDR_DAC2A_VOLUME, d); `CHK("volume re-reset", RST_DAC2A_VOLUME, d)
		`CHK("level re-reset", LEVEL_ZERO_DB, neg_leg_level_sel)
		`CHK("fine re-reset", FGAIN_UNITY, ch2a_fine_gain_code)
		end_of_test;
	end
endmodule
